//--- rtl/fsp_regs.sv
// Overview of operation
// - Reset loads option register from flash byte.
// - Option register ignores all software writes.
// - Backdoor enable low blocks key unlock.
// - Key writes accepted only from non-debug firmware.
// - Matching ascending eight-byte key releases security.
// - Bit six disables vector redirection.
// - Only security code 1:0 means unsecured.
// - Secured blocks unsecured-source memory accesses.
// - Key match or blank check forces 1:0.
// - Key access routes key window to key.
// - Reset loads protection register from flash byte.
// - Protection readable; writable when protection disabled.
// - Enabled protection only accepts region growth.
// - Debug commands may modify protection register.
// - Protect select sets unprotected end address.
// - Protection-disable bit zero, when set, unprotects everything.
// - Clearing key access compares written key.
// - Protected erase/program ignored, violation flag set.
`timescale 1ns/1ps
`default_nettype none
`include "fsp_cfg.svh"

module fsp_regs (
	// Clock and reset
	input  wire logic           core_clk_in,
	input  wire logic           rst_in,
	// Nonvolatile bytes presented by the flash array
	input  wire logic [7:0]     nonvolatile_option_byte_in,
	input  wire logic [7:0]     nonvolatile_protect_byte_in,
	input  wire logic [63:0]    stored_backdoor_key_in,
	// CPU side writes toward key window or command path
	input  wire fsp_pkg::fsp_wr_s cpu_wr_in,
	// Access check from the memory arbiter
	input  wire logic           mem_req_in,
	input  wire logic           mem_src_secure_in,
	// Command sequencer hand-off
	input  wire logic           blank_check_ok_in,
	input  wire logic           cmd_erase_prog_in,
	input  wire logic [15:0]    cmd_addr_in,
	// AHB-Lite slave
	input  wire logic           hsel_in,
	input  wire logic [31:0]    haddr_in,
	input  wire logic [1:0]     htrans_in,
	input  wire logic           hwrite_in,
	input  wire logic [2:0]     hsize_in,
	input  wire logic [31:0]    hwdata_in,
	input  wire logic           hready_in,
	input  wire logic           hdebug_in,
	output logic [31:0]         hrdata_out,
	output logic                hreadyout_out,
	output logic                hresp_out,
	// Block outputs
	output logic                secured_out,
	output logic                redirection_disable_out,
	output logic                mem_block_out,
	output logic                cmd_start_out,
	output logic [15:0]         cmd_start_addr_out,
	output logic [7:0]          cmd_start_data_out,
	output logic                cmd_accept_out,
	output logic                irq_out
);

	logic [7:0]                 flash_option_copy;
	logic [7:0]                 flash_config;
	logic [7:0]                 flash_protect_control;
	logic [63:0]                key_buf;
	logic [2:0]                 key_idx;
	fsp_pkg::fsp_key_e          key_state;
	logic [`FSP_IRQ_WIDTH-1:0]  irq_status;
	logic [`FSP_IRQ_WIDTH-1:0]  irq_mask;
	logic                       loaded;
	logic                       ap_valid;
	logic                       ap_write;
	logic                       ap_debug;
	logic [11:0]                ap_addr;
	logic                       key_window;
	logic                       key_wr;
	logic                       key_access_enable_clear;
	logic                       key_match;
	logic                       cmd_protected;
	logic                       viol_evt;
	logic                       wr_prot;
	logic [7:0]                 wdata;
	logic [`FSP_IRQ_WIDTH-1:0]  irq_events;
	logic [`FSP_IRQ_WIDTH-1:0]  irq_clear;
	logic [31:0]                next_rdata;
	logic                       wr_config;
	logic                       wr_irq_status;
	logic                       wr_irq_mask;
	logic                       prot_grows;
	logic                       key_fail;
	logic                       key_in_order;

	// Registered address phase; the slave always answers with zero wait states.
	// The debug qualifier travels with the address phase but filters nothing, since
	// debug and firmware may both write the protection register.
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			ap_valid <= 1'b0;
			ap_write <= 1'b0;
			ap_debug <= 1'b0;
			ap_addr  <= 12'h000;
		end else if (hready_in) begin
			ap_valid <= hsel_in && htrans_in[1] && (hsize_in == 3'h2);
			ap_write <= hwrite_in;
			ap_debug <= hdebug_in;
			ap_addr  <= {haddr_in[`FSP_ADDR_MSB:`FSP_ADDR_WORD_LSB], 2'b00};
		end
	end

	assign wdata = hwdata_in[7:0];
	assign wr_prot = ap_valid && ap_write && (ap_addr == `FSP_ADDR_PROTECT);
	assign wr_config = ap_valid && ap_write && (ap_addr == `FSP_ADDR_CONFIG);
	assign wr_irq_status = ap_valid && ap_write && (ap_addr == `FSP_ADDR_IRQ_STATUS);
	assign wr_irq_mask = ap_valid && ap_write && (ap_addr == `FSP_ADDR_IRQ_MASK);
	// The compare fires only on a one-to-zero change of key access, so rewriting a
	// zero cannot replay an earlier attempt.
	assign key_access_enable_clear = wr_config
		&& flash_config[`FSP_CFG_KEY_ACCESS_ENABLE_BIT] && !wdata[`FSP_CFG_KEY_ACCESS_ENABLE_BIT];

	// A smaller select value moves the boundary down and protects more; an equal
	// value changes nothing and is dropped like a shrink.
	assign prot_grows = (wdata[7:1] < flash_protect_control[7:1])
		&& !wdata[`FSP_PROT_DIS_BIT];

	// The first clocked cycle after reset release captures the flash bytes, since an
	// asynchronous reset may only load constants.
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			loaded <= 1'b0;
		end else begin
			loaded <= 1'b1;
		end
	end

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			flash_option_copy <= 8'h00;
		end else if (!loaded) begin
			flash_option_copy <= nonvolatile_option_byte_in & `FSP_OPT_MASK;
		// After load only the security field moves, and only toward unsecured.
		end else if (key_match || blank_check_ok_in) begin
			flash_option_copy[1:0] <= `FSP_SEC_UNSECURED;
		end
		// Software writes never land here.
	end

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			flash_config <= 8'h00;
		end else if (wr_config) begin
			flash_config <= wdata & `FSP_CFG_MASK;
		end
	end

	// Shrinking writes are dropped whole, including the disable bit.
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			flash_protect_control <= 8'h00;
		end else if (!loaded) begin
			// The load bypasses the growth check on purpose.
			flash_protect_control <= nonvolatile_protect_byte_in;
		end else if (wr_prot) begin
			if (flash_protect_control[`FSP_PROT_DIS_BIT]) begin
				flash_protect_control <= wdata;
			end else if (prot_grows) begin
				flash_protect_control <= wdata;
			end
		end
	end

	// Key window decode and routing.
	assign key_window = cpu_wr_in.valid
		&& (cpu_wr_in.addr[15:3] == 13'(`FSP_KEY_BASE >> 3));
	assign key_wr = key_window && flash_config[`FSP_CFG_KEY_ACCESS_ENABLE_BIT]
		&& !cpu_wr_in.from_debug;
	assign key_in_order = cpu_wr_in.addr[2:0] == key_idx;

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			key_state <= fsp_pkg::FSP_KEY_IDLE;
			key_idx   <= 3'h0;
			key_buf   <= 64'h0000_0000_0000_0000;
		end else if (key_access_enable_clear) begin
			key_state <= fsp_pkg::FSP_KEY_IDLE;
			key_idx   <= 3'h0;
		end else if (key_wr) begin
			unique case (key_state)
				fsp_pkg::FSP_KEY_IDLE,
				fsp_pkg::FSP_KEY_COLLECT: begin
					// Bytes must arrive in ascending address order.
					if (key_in_order) begin
						key_buf[63 - 8*key_idx -: 8] <= cpu_wr_in.data;
						key_idx   <= key_idx + 3'h1;
						key_state <= fsp_pkg::FSP_KEY_COLLECT;
						if (key_idx == `FSP_KEY_LAST) begin
							key_idx <= `FSP_KEY_LAST;
						end
					end else begin
						// A stray byte spoils the attempt until key access is cleared.
						key_state <= fsp_pkg::FSP_KEY_BAD;
					end
				end
				fsp_pkg::FSP_KEY_BAD: begin
					key_state <= fsp_pkg::FSP_KEY_BAD;
				end
				default: begin
					key_state <= fsp_pkg::FSP_KEY_BAD;
				end
			endcase
		end
	end

	// Seven bytes stored plus the idx stuck at last means all eight came in.
	logic key_complete;
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			key_complete <= 1'b0;
		end else if (key_access_enable_clear) begin
			key_complete <= 1'b0;
		end else if (key_wr && key_state != fsp_pkg::FSP_KEY_BAD
			&& cpu_wr_in.addr[2:0] == `FSP_KEY_LAST && key_idx == `FSP_KEY_LAST) begin
			key_complete <= 1'b1;
		end else if (key_wr) begin
			key_complete <= 1'b0;
		end
	end

	assign key_match = key_access_enable_clear && key_complete
		&& (key_state == fsp_pkg::FSP_KEY_COLLECT)
		&& flash_option_copy[`FSP_OPT_BACKDOOR_ENABLE_BIT]
		&& (key_buf == stored_backdoor_key_in);

	// Any compare that does not unlock counts as a failure, a disabled backdoor too.
	assign key_fail = key_access_enable_clear && !key_match;

	// Protection check: region above the protect select boundary is locked.
	assign cmd_protected = !flash_protect_control[`FSP_PROT_DIS_BIT]
		&& (cmd_addr_in[15:9] > flash_protect_control[7:1]);
	assign viol_evt = cmd_erase_prog_in && cmd_protected;

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			cmd_accept_out <= 1'b0;
		end else begin
			cmd_accept_out <= cmd_erase_prog_in && !cmd_protected;
		end
	end

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			cmd_start_out      <= 1'b0;
			cmd_start_addr_out <= 16'h0000;
			cmd_start_data_out <= 8'h00;
		end else begin
			cmd_start_out <= key_window && !flash_config[`FSP_CFG_KEY_ACCESS_ENABLE_BIT];
			// Address and data of the last CPU write stay put until the next one, so
			// the sequencer may pick them up after the start pulse.
			if (cpu_wr_in.valid) begin
				cmd_start_addr_out <= cpu_wr_in.addr;
				cmd_start_data_out <= cpu_wr_in.data;
			end
		end
	end

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			secured_out             <= 1'b1;
			redirection_disable_out <= 1'b0;
			mem_block_out           <= 1'b0;
		end else begin
			// Security leaves a flop so downstream gating never sees a glitch.
			secured_out <= flash_option_copy[1:0] != `FSP_SEC_UNSECURED;
			redirection_disable_out <= flash_option_copy[`FSP_OPT_NORED_BIT];
			// Blocking follows the registered security state, so it lags an unlock by
			// one cycle and errs toward refusing.
			mem_block_out <= mem_req_in && !mem_src_secure_in && secured_out;
		end
	end

	// Interrupts: set wins over write-one-to-clear.
	assign irq_events = {key_fail, key_match || blank_check_ok_in, viol_evt};
	assign irq_clear = wr_irq_status ? hwdata_in[`FSP_IRQ_WIDTH-1:0] : '0;

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			irq_status <= '0;
			irq_mask   <= '0;
			irq_out    <= 1'b0;
		end else begin
			irq_status <= (irq_status & ~irq_clear) | irq_events;
			if (wr_irq_mask) begin
				irq_mask <= hwdata_in[`FSP_IRQ_WIDTH-1:0];
			end
			// Built from the next status so an event reaches the pin with its bit.
			irq_out <= |(((irq_status & ~irq_clear) | irq_events) & irq_mask);
		end
	end

	// Unmapped offsets read as zero, so software may probe the map safely.
	always_comb begin
		next_rdata = 32'h0000_0000;
		unique case (haddr_in[`FSP_ADDR_MSB:0] & 12'hFFC)
			`FSP_ADDR_OPTION:     next_rdata[7:0] = flash_option_copy;
			`FSP_ADDR_CONFIG:     next_rdata[7:0] = flash_config;
			`FSP_ADDR_PROTECT:    next_rdata[7:0] = flash_protect_control;
			`FSP_ADDR_IRQ_STATUS: next_rdata[`FSP_IRQ_WIDTH-1:0] = irq_status;
			`FSP_ADDR_IRQ_MASK:   next_rdata[`FSP_IRQ_WIDTH-1:0] = irq_mask;
			`FSP_ADDR_STATE:      next_rdata[3:0] = {key_complete, key_idx};
			default:              next_rdata = 32'h0000_0000;
		endcase
	end

	// Read data captured in the address phase so it stands through the data phase.
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			hrdata_out    <= 32'h0000_0000;
			hreadyout_out <= 1'b1;
			hresp_out     <= 1'b0;
		end else begin
			hreadyout_out <= 1'b1;
			hresp_out     <= 1'b0;
			if (hready_in && hsel_in && htrans_in[1] && !hwrite_in) begin
				hrdata_out <= next_rdata;
			end
		end
	end

endmodule
`default_nettype wire

//--- rtl/fsp_cfg.svh
`ifndef FSP_CFG_SVH
`define FSP_CFG_SVH

// Register byte addresses on the AHB-Lite slave.
`define FSP_ADDR_OPTION     12'h000
`define FSP_ADDR_CONFIG     12'h004
`define FSP_ADDR_PROTECT    12'h008
`define FSP_ADDR_IRQ_STATUS 12'h00C
`define FSP_ADDR_IRQ_MASK   12'h010
`define FSP_ADDR_KEY_LO     12'h014
`define FSP_ADDR_KEY_HI     12'h018
`define FSP_ADDR_STATE      12'h01C
`define FSP_ADDR_CMD        12'h020
`define FSP_ADDR_MSB        11
`define FSP_ADDR_WORD_LSB   2

// Option register fields.
`define FSP_OPT_BACKDOOR_ENABLE_BIT   7
`define FSP_OPT_NORED_BIT   6
`define FSP_OPT_MASK        8'hC3
`define FSP_SEC_UNSECURED   2'h2

// Configuration register fields.
`define FSP_CFG_KEY_ACCESS_ENABLE_BIT  5
`define FSP_CFG_MASK        8'h20

// Protection register fields.
`define FSP_PROT_DIS_BIT    0

// Key window in the CPU address map.
`define FSP_KEY_BASE        16'hFFB0
`define FSP_KEY_LAST        3'h7
`define FSP_KEY_BYTES       8

// Interrupt status bit positions.
`define FSP_IRQ_VIOL        0
`define FSP_IRQ_UNLOCK      1
`define FSP_IRQ_KEYFAIL     2
`define FSP_IRQ_WIDTH       3

`endif

//--- rtl/fsp_pkg.sv
package fsp_pkg;
	// A CPU-side write toward the flash key window or command path.
	typedef struct packed {
		logic        valid;
		logic        from_debug;
		logic [15:0] addr;
		logic [7:0]  data;
	} fsp_wr_s;

	typedef enum logic [1:0] {
		FSP_KEY_IDLE,
		FSP_KEY_COLLECT,
		FSP_KEY_BAD
	} fsp_key_e;
endpackage

//--- tb/fsp_regs_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module fsp_regs_chk (
	input wire logic             core_clk_in,
	input wire logic             rst_in,
	input wire logic [7:0]       nonvolatile_option_byte_in,
	input wire fsp_pkg::fsp_wr_s cpu_wr_in,
	input wire logic             mem_req_in,
	input wire logic             mem_src_secure_in,
	input wire logic             blank_check_ok_in,
	input wire logic             cmd_erase_prog_in,
	input wire logic             secured_out,
	input wire logic             redirection_disable_out,
	input wire logic             mem_block_out,
	input wire logic             cmd_start_out,
	input wire logic [15:0]      cmd_start_addr_out,
	input wire logic             cmd_accept_out
);
	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (rst_in);
	chk_sec_load: assert property (
		$fell(rst_in) |-> ##2 secured_out == (nonvolatile_option_byte_in[1:0] != 2'h2))
		else $error("secured level wrong after load");
	chk_redir_load: assert property (
		$fell(rst_in) |-> ##2 redirection_disable_out == nonvolatile_option_byte_in[6])
		else $error("redirection level wrong after load");
	chk_redir_hold: assert property (
		!$past(rst_in) && !$past(rst_in, 2) && !$past(rst_in, 3)
		|-> $stable(redirection_disable_out))
		else $error("option copy changed outside reset");
	chk_unsec_sticky: assert property (!secured_out |=> !secured_out)
		else $error("security came back before reset");
	chk_blank_unlock: assert property (blank_check_ok_in |-> ##[1:2] !secured_out)
		else $error("blank check did not unsecure");
	chk_mem_block: assert property (
		!$past(rst_in) |->
		mem_block_out == $past(mem_req_in && !mem_src_secure_in && secured_out))
		else $error("memory block wrong");
	chk_accept_cause: assert property (cmd_accept_out |-> $past(cmd_erase_prog_in))
		else $error("accept without command");
	chk_start_cause: assert property (
		cmd_start_out |-> $past(cpu_wr_in.valid) && cmd_start_addr_out[15:3] == 13'h1FF6)
		else $error("command start without window write");
	cov_unlock: cover property ($fell(secured_out));
	cov_accept: cover property (cmd_accept_out);
	cov_block: cover property (mem_block_out);
endmodule
bind fsp_regs fsp_regs_chk u_fsp_chk (.*);
`default_nettype wire

//--- tb/fsp_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
// Idle cycles scramble address and data so a stale byte never looks valid.
module fsp_cpu_model (
	input  wire logic            clk_in,
	input  wire logic            go_in,
	input  wire logic            dbg_in,
	input  wire logic [15:0]     addr_in,
	input  wire logic [7:0]      data_in,
	output var fsp_pkg::fsp_wr_s wr_out
);
	initial wr_out = '0;
	always @(posedge clk_in) begin
		wr_out.valid <= go_in;
		wr_out.from_debug <= dbg_in;
		wr_out.addr <= go_in ? addr_in : ~wr_out.addr;
		wr_out.data <= go_in ? data_in : ~wr_out.data;
	end
endmodule
`default_nettype wire

//--- tb/test_flash_security_protection_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "fsp_cfg.svh"
module test_flash_security_protection_regs;
	logic             clk = 1'b0;
	logic             rst_in = 1'b1;
	logic [7:0]       nonvolatile_option_byte = 8'h00;
	logic [7:0]       nonvolatile_protect_byte = 8'h00;
	logic [63:0]      key = 64'h0;
	logic             go = 1'b0;
	logic             dbg = 1'b0;
	logic [15:0]      ca = 16'h0;
	logic [7:0]       cd = 8'h00;
	logic             mreq = 1'b0;
	logic             msec = 1'b0;
	logic             blank = 1'b0;
	logic             cmd = 1'b0;
	logic [15:0]      cmda = 16'h0;
	logic [31:0]      haddr = 32'h0;
	logic [1:0]       htrans = 2'h0;
	logic             hwrite = 1'b0;
	logic [31:0]      hwdata = 32'h0;
	logic             rd_ph = 1'b0;
	logic             hdbg = 1'b0;
	logic [15:0]      csa;
	logic [7:0]       csd;
	logic             resp;
	logic [31:0]      hrdata;
	logic             hrdy;
	logic             sec;
	logic             redir;
	logic             mblk;
	logic             cst;
	logic             acc;
	logic             irq;
	fsp_pkg::fsp_wr_s cpu_wr;
	logic [31:0]      exp_q[$];
	int               err_total = 0;
	int               total_checks = 0;
	int               seed = 81222;
	int               cyc = 0;
	always #12.5 clk = ~clk;
	fsp_cpu_model u_cpu (.clk_in(clk), .go_in(go), .dbg_in(dbg), .addr_in(ca), .data_in(cd),
		.wr_out(cpu_wr));
	fsp_regs dut (.core_clk_in(clk), .rst_in(rst_in), .nonvolatile_option_byte_in(nonvolatile_option_byte),
		.nonvolatile_protect_byte_in(nonvolatile_protect_byte), .stored_backdoor_key_in(key), .cpu_wr_in(cpu_wr),
		.mem_req_in(mreq), .mem_src_secure_in(msec), .blank_check_ok_in(blank),
		.cmd_erase_prog_in(cmd), .cmd_addr_in(cmda), .hsel_in(1'b1), .haddr_in(haddr),
		.htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
		.hready_in(hrdy), .hdebug_in(hdbg), .hrdata_out(hrdata), .hreadyout_out(hrdy),
		.hresp_out(resp), .secured_out(sec), .redirection_disable_out(redir),
		.mem_block_out(mblk), .cmd_start_out(cst), .cmd_start_addr_out(csa),
		.cmd_start_data_out(csd), .cmd_accept_out(acc), .irq_out(irq));
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			err_total++;
			$display("wrong value at %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic cmpb(input logic g, input logic e);
		cmp({31'h0, g}, {31'h0, e});
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Read data is judged by the watcher at the data-phase edge, not by the driver.
	always @(posedge clk) begin
		cyc++;
		if (rd_ph && hrdy === 1'b1) begin
			cmp(hrdata, exp_q.pop_front());
			cmpb(resp, 1'b0);
		end
		if (cyc == 4000) begin
			err_total++;
			finish_test;
		end
	end
	task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge clk); while (hrdy !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		rd_ph <= !w;
		do @(posedge clk); while (hrdy !== 1'b1);
		rd_ph <= 1'b0;
	endtask
	task automatic rd(input logic [31:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus(a, 1'b0, $random(seed));
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		bus(a, 1'b1, d);
	endtask
	// Registered levels may trail their cause by a cycle, so two edges pass first.
	task automatic lvl(input logic s, input logic e);
		repeat (2) @(posedge clk);
		@(negedge clk);
		cmpb(s ? sec : irq, e);
		@(posedge clk);
	endtask
	task automatic reset(input logic [7:0] o, input logic [7:0] p);
		nonvolatile_option_byte <= o;
		nonvolatile_protect_byte <= p;
		rst_in <= 1'b1;
		repeat (20) @(posedge clk);
		rst_in <= 1'b0;
		lvl(1'b1, o[1:0] != 2'h2);
		cmpb(redir, o[6]);
	endtask
	task automatic cpu(input logic [15:0] a, input logic [7:0] d, input logic g, input logic e);
		ca <= a;
		cd <= d;
		dbg <= g;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		@(posedge clk);
		@(negedge clk);
		cmpb(cst, e);
		if (e) cmp({csa, 8'h00, csd}, {a, 8'h00, d});
		@(posedge clk);
	endtask
	task automatic poke(input int k, input logic [15:0] a, input logic s, input logic e);
		mreq <= k == 0;
		msec <= s;
		cmd <= k == 1;
		cmda <= a;
		@(posedge clk);
		mreq <= 1'b0;
		cmd <= 1'b0;
		@(negedge clk);
		cmpb(k == 0 ? mblk : acc, e);
		@(posedge clk);
	endtask
	task automatic key_try(input logic g, input logic e);
		wr(`FSP_ADDR_CONFIG, 32'h0000_0020);
		rd(`FSP_ADDR_CONFIG, 32'h0000_0020);
		for (int i = 0; i < 8; i++)
			cpu(16'hFFB0 + 16'(i), key[63 - 8 * i -: 8], g, 1'b0);
		wr(`FSP_ADDR_CONFIG, 32'h0000_0000);
		lvl(1'b1, e);
	endtask
	initial begin
		key = {$random(seed), $random(seed)};
		reset(8'hC0, 8'h80);
		rd(`FSP_ADDR_OPTION, 32'h0000_00C0);
		rd(`FSP_ADDR_PROTECT, 32'h0000_0080);
		wr(`FSP_ADDR_OPTION, $random(seed));
		rd(`FSP_ADDR_OPTION, 32'h0000_00C0);
		rd(32'h0000_0040, 32'h0000_0000);
		poke(0, 16'h0, 1'b0, 1'b1);
		poke(0, 16'h0, 1'b1, 1'b0);
		$display("reset and option test done");
		wr(`FSP_ADDR_IRQ_MASK, 32'h0000_0007);
		wr(`FSP_ADDR_PROTECT, 32'h0000_00A0);
		wr(`FSP_ADDR_PROTECT, 32'h0000_0061);
		rd(`FSP_ADDR_PROTECT, 32'h0000_0080);
		wr(`FSP_ADDR_PROTECT, 32'h0000_0060);
		rd(`FSP_ADDR_PROTECT, 32'h0000_0060);
		poke(1, 16'h6000, 1'b0, 1'b1);
		poke(1, 16'h6200, 1'b0, 1'b0);
		rd(`FSP_ADDR_IRQ_STATUS, 32'h0000_0001);
		lvl(1'b0, 1'b1);
		wr(`FSP_ADDR_IRQ_MASK, 32'h0000_0000);
		lvl(1'b0, 1'b0);
		wr(`FSP_ADDR_IRQ_STATUS, 32'h0000_0001);
		rd(`FSP_ADDR_IRQ_STATUS, 32'h0000_0000);
		$display("protection test done");
		cpu(16'hFFB3, 8'h5A, 1'b0, 1'b1);
		key_try(1'b1, 1'b1);
		key_try(1'b0, 1'b0);
		rd(`FSP_ADDR_OPTION, 32'h0000_00C2);
		rd(`FSP_ADDR_IRQ_STATUS, 32'h0000_0006);
		poke(0, 16'h0, 1'b0, 1'b0);
		$display("backdoor key test done");
		reset(8'h01, 8'h01);
		poke(1, 16'hFE00, 1'b0, 1'b1);
		hdbg <= 1'b1;
		wr(`FSP_ADDR_PROTECT, 32'h0000_00FE);
		hdbg <= 1'b0;
		rd(`FSP_ADDR_PROTECT, 32'h0000_00FE);
		key_try(1'b0, 1'b1);
		blank <= 1'b1;
		@(posedge clk);
		blank <= 1'b0;
		lvl(1'b1, 1'b0);
		rd(`FSP_ADDR_OPTION, 32'h0000_0002);
		$display("blank check test done");
		finish_test;
	end
endmodule
`default_nettype wire
